// >>> hdl/aluop_core.v
// execute-stage datapath: add, add with carry, shifts, branches
// assumes decoded fields from same-clock decode logic, apb master
//
// What this block does
// RULE1: keep carry, digit carry, negative, overflow, zero
// RULE2: sixteen working registers picked by 4-bit fields
// RULE3: file-form accumulator result goes to register 0
// RULE4: byte, word or double-word size, word default
// RULE5: 4-bit bit index selects bit 0..15
// RULE6: file address field covers 0000h to 1FFFh
// RULE7: 10-bit literal limited to 255 in byte mode
// RULE8: 5-bit literal zero-extended as second operand
// RULE9: 8-bit and 16-bit literals zero-extended
// RULE10: program address literal lsb must be zero
// RULE11: 10-bit signed literal sign-extended before use
// RULE12: direct, indirect, pre/post increment, indexed sources
// RULE13: add and carry-add one cycle, all five flags
// RULE14: asr one keeps sign; multi-bit updates n,z only
// RULE15: conditional branch one cycle, two if taken
// RULE16: carry-add only clears zero, never sets it
// RULE17: taken branch turns next cycle into no-op
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "aluop_defs.vh"

module aluop_core (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  // decoded instruction
  input wire ins_valid,
  input wire [2:0] ins_op,
  input wire [1:0] ins_size,
  input wire [3:0] ins_src_mode,
  input wire ins_to_acc,
  input wire [1:0] ins_cond,
  input wire [3:0] base_reg_field,
  input wire [3:0] source_reg_field,
  input wire [3:0] dest_reg_field,
  input wire [3:0] bit_index_field,
  input wire [4:0] imm5_field,
  input wire [9:0] imm10_field,
  input wire [9:0] simm10_field,
  input wire [7:0] imm8_field,
  input wire [15:0] imm16_field,
  input wire [12:0] file_addr_field,
  input wire [22:0] prog_addr_literal,
  input wire [15:0] mem_operand,
  // results
  output reg carry_flag,
  output reg digit_carry_flag,
  output reg negative_flag,
  output reg overflow_flag,
  output reg zero_flag,
  output reg [15:0] result_q,
  output reg file_wr_q,
  output reg [12:0] file_addr_q,
  output reg [15:0] ea_q,
  output reg ea_valid_q,
  output reg branch_taken_q,
  output reg [15:0] branch_offset_q,
  output reg nop_cycle_q,
  output reg bit_value_q,
  output reg illegal_q
);

  // ==========================================================
  // register file
  wire [255:0] rf;
  wire [15:0] rf_apb_rd;
  reg we0, we1;
  reg [3:0] wa0, wa1;
  reg [15:0] wd0, wd1;
  reg ctrl_run_q;

  aluop_regfile u_rf (
    .pclk(pclk),
    .presetn(presetn),
    .we0(we0),
    .wa0(wa0),
    .wd0(wd0),
    .we1(we1),
    .wa1(wa1),
    .wd1(wd1),
    .ra(paddr[5:2]),
    .rd_q(rf_apb_rd),
    .flat(rf)
  );

  wire [15:0] w_base = rf[base_reg_field*16 +: 16]; // [RULE2]
  wire [15:0] w_base1 = rf[{base_reg_field + 4'h1}*16 +: 16];
  wire [15:0] w_src = rf[source_reg_field*16 +: 16];
  wire [15:0] w_src1 = rf[{source_reg_field + 4'h1}*16 +: 16];
  wire [15:0] w_dst = rf[dest_reg_field*16 +: 16];
  wire [15:0] w_acc = rf[`ALUOP_ACC_REG*16 +: 16]; // [RULE3]

  // ==========================================================
  // operand selection
  wire exec = ins_valid & ctrl_run_q & ~nop_cycle_q; // [RULE17]
  wire sz_byte = (ins_size == `ALUOP_SZ_BYTE); // [RULE4]
  wire sz_dw = (ins_size == `ALUOP_SZ_DWORD);
  wire [15:0] inc = sz_byte ? `ALUOP_INC_BYTE : `ALUOP_INC_WORD;
  wire [15:0] simm_ext = {{6{simm10_field[9]}}, simm10_field}; // [RULE11]
  reg [15:0] src_op;
  reg [31:0] op_a, op_b;

  always @* begin
    case (ins_src_mode) // [RULE12]
      `ALUOP_SRC_REG: src_op = w_src;
      `ALUOP_SRC_IND, `ALUOP_SRC_POSTINC, `ALUOP_SRC_PREINC,
      `ALUOP_SRC_IDX, `ALUOP_SRC_FILE: src_op = mem_operand;
      `ALUOP_SRC_IMM5: src_op = {11'h000, imm5_field}; // [RULE8]
      `ALUOP_SRC_IMM10: src_op = {6'h00, imm10_field};
      `ALUOP_SRC_SIMM10: src_op = simm_ext;
      `ALUOP_SRC_IMM8: src_op = {8'h00, imm8_field}; // [RULE9]
      `ALUOP_SRC_IMM16: src_op = imm16_field; // [RULE9]
      default: src_op = 16'h0000;
    endcase
    if (ins_src_mode == `ALUOP_SRC_FILE) begin
      op_a = {16'h0000, mem_operand};
      op_b = {16'h0000, w_acc}; // [RULE3]
    end else if (ins_src_mode == `ALUOP_SRC_IMM10) begin
      op_a = {16'h0000, w_dst};
      op_b = {16'h0000, src_op};
    end else if (sz_dw) begin
      op_a = {w_base1, w_base}; // [RULE4]
      op_b = {w_src1, w_src};
    end else begin
      op_a = {16'h0000, w_base};
      op_b = {16'h0000, src_op};
    end
    if (sz_byte) begin
      op_a = {24'h000000, op_a[7:0]};
      op_b = {24'h000000, op_b[7:0]};
    end
  end

  // ==========================================================
  // adder and shifter
  wire cin = (ins_op == `ALUOP_OP_ADD_WITH_CARRY) & carry_flag; // [RULE13]
  wire [32:0] sum = {1'b0, op_a} + {1'b0, op_b} + {32'h0, cin};
  wire [4:0] nib = op_a[3:0] + op_b[3:0] + {3'h0, cin};
  wire [8:0] lob = op_a[7:0] + op_b[7:0] + {8'h00, cin};
  wire [16:0] low = op_a[15:0] + op_b[15:0] + {16'h0000, cin};
  wire [15:0] sh_in = (ins_op == `ALUOP_OP_ASRN) ? w_base :
    ((ins_src_mode == `ALUOP_SRC_FILE) ? mem_operand : src_op);
  wire [31:0] sh_ext = sz_byte ? {{24{sh_in[7]}}, sh_in[7:0]} :
    {{16{sh_in[15]}}, sh_in};
  wire [4:0] sh_cnt = (ins_src_mode == `ALUOP_SRC_IMM5) ? imm5_field :
    {1'b0, w_src[3:0]};
  wire [31:0] sh1 = $signed(sh_ext) >>> 1; // [RULE14]
  wire [31:0] shn = $signed(sh_ext) >>> sh_cnt; // [RULE14]

  reg [31:0] res;
  reg c_n, dc_n, n_n, ov_n, z_n, sa, sb, sr;
  reg upd_c, upd_dc, upd_ov, upd_nz, is_arith, cond_ok;

  always @* begin
    res = 32'h0;
    c_n = carry_flag;
    dc_n = digit_carry_flag;
    ov_n = overflow_flag;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_ov = 1'b0;
    upd_nz = 1'b0;
    is_arith = 1'b0;
    sa = op_a[15];
    sb = op_b[15];
    case (ins_op)
      `ALUOP_OP_ADD, `ALUOP_OP_ADD_WITH_CARRY: begin
        res = sum[31:0];
        is_arith = 1'b1;
        upd_c = 1'b1;
        upd_dc = 1'b1;
        upd_ov = 1'b1;
        upd_nz = 1'b1; // [RULE13]
        if (sz_byte) begin
          c_n = lob[8];
          dc_n = nib[4];
          sa = op_a[7];
          sb = op_b[7];
        end else if (sz_dw) begin
          c_n = sum[32];
          dc_n = low[16];
          sa = op_a[31];
          sb = op_b[31];
        end else begin
          c_n = low[16];
          dc_n = lob[8];
        end
      end
      `ALUOP_OP_ASR1: begin
        res = sh1;
        upd_c = 1'b1;
        upd_ov = 1'b1;
        upd_nz = 1'b1; // [RULE14]
        c_n = sh_in[0];
      end
      `ALUOP_OP_ASRN: begin
        res = shn;
        upd_nz = 1'b1; // [RULE14]
      end
      default: res = 32'h0;
    endcase
    if (sz_byte) begin
      res = {24'h000000, res[7:0]};
      sr = res[7];
      z_n = (res[7:0] == 8'h00);
    end else if (sz_dw) begin
      sr = res[31];
      z_n = (res == 32'h0);
    end else begin
      res = {16'h0000, res[15:0]};
      sr = res[15];
      z_n = (res[15:0] == 16'h0000);
    end
    n_n = sr;
    if (is_arith) begin
      ov_n = (sa == sb) & (sr != sa);
    end else begin
      ov_n = 1'b0;
    end
    case (ins_cond)
      `ALUOP_CC_C, `ALUOP_CC_GEU: cond_ok = carry_flag;
      `ALUOP_CC_GE: cond_ok = (negative_flag == overflow_flag);
      `ALUOP_CC_GT: cond_ok = ~zero_flag &
        (negative_flag == overflow_flag);
      default: cond_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // legality and effective address
  wire bad_imm10 = (ins_src_mode == `ALUOP_SRC_IMM10) & sz_byte &
    (imm10_field > `ALUOP_IMM10_BYTE_MAX); // [RULE7]
  wire bad_prog = prog_addr_literal[0]; // [RULE10]
  wire bad = bad_imm10 |
    ((ins_op == `ALUOP_OP_BRA) & bad_prog);
  wire mem_form = (ins_src_mode == `ALUOP_SRC_IND) |
    (ins_src_mode == `ALUOP_SRC_POSTINC) |
    (ins_src_mode == `ALUOP_SRC_PREINC) |
    (ins_src_mode == `ALUOP_SRC_IDX);
  reg [15:0] ea;

  always @* begin
    case (ins_src_mode) // [RULE12]
      `ALUOP_SRC_PREINC: ea = w_src + inc;
      `ALUOP_SRC_IDX: ea = w_src + w_base;
      default: ea = w_src;
    endcase
  end

  // ==========================================================
  // apb decode
  wire apb_go = psel & penable & pready_q;
  wire sel_rf = (paddr[`ALUOP_RF_SEL_MSB:`ALUOP_RF_SEL_LSB] ==
    `ALUOP_RF_SEL_VAL);
  wire sel_st = (paddr == `ALUOP_ADDR_STATUS);
  wire sel_ct = (paddr == `ALUOP_ADDR_CTRL);
  wire sel_rs = (paddr == `ALUOP_ADDR_RESULT);
  wire mapped = sel_rf | sel_st | sel_ct | sel_rs;
  // running core owns the write ports, so apb rf writes need halt
  wire apb_rf_wr = apb_go & pwrite & sel_rf & ~ctrl_run_q;
  wire do_alu = exec & ~bad & (ins_op != `ALUOP_OP_BRA) &
    (ins_op != `ALUOP_OP_NOP) & (ins_op != `ALUOP_OP_BITSEL);
  wire to_file = (ins_src_mode == `ALUOP_SRC_FILE) & ~ins_to_acc;

  // ==========================================================
  // write-back steering
  always @* begin
    we0 = 1'b0;
    wa0 = dest_reg_field;
    wd0 = res[15:0];
    we1 = 1'b0;
    wa1 = dest_reg_field + 4'h1;
    wd1 = res[31:16];
    if (do_alu & ~to_file) begin
      we0 = 1'b1;
      if (ins_src_mode == `ALUOP_SRC_FILE) begin
        wa0 = `ALUOP_ACC_REG; // [RULE3]
      end
      if (sz_byte) begin
        wd0 = {rf[wa0*16 + 8 +: 8], res[7:0]};
      end
      if (sz_dw & (ins_src_mode == `ALUOP_SRC_REG)) begin
        we1 = 1'b1; // [RULE4]
      end
    end
    if (exec & ~bad & ((ins_src_mode == `ALUOP_SRC_POSTINC) |
        (ins_src_mode == `ALUOP_SRC_PREINC))) begin
      we1 = 1'b1; // [RULE12]
      wa1 = source_reg_field;
      wd1 = w_src + inc;
    end
    if (apb_rf_wr) begin
      we0 = 1'b1;
      wa0 = paddr[5:2];
      wd0 = pwdata[15:0];
    end
  end

  // ==========================================================
  // flags, control and outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_flag <= 1'b0;
      digit_carry_flag <= 1'b0;
      negative_flag <= 1'b0;
      overflow_flag <= 1'b0;
      zero_flag <= 1'b0;
      ctrl_run_q <= `ALUOP_CTRL_RESET;
      result_q <= 16'h0000;
      file_wr_q <= 1'b0;
      file_addr_q <= 13'h0000;
      ea_q <= 16'h0000;
      ea_valid_q <= 1'b0;
      branch_taken_q <= 1'b0;
      branch_offset_q <= 16'h0000;
      nop_cycle_q <= 1'b0;
      bit_value_q <= 1'b0;
      illegal_q <= 1'b0;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      if (apb_go & pwrite & sel_ct) begin
        ctrl_run_q <= pwdata[0];
      end
      // software load first so an instruction update overrides it
      if (apb_go & pwrite & sel_st) begin
        carry_flag <= pwdata[`ALUOP_FLAG_C];
        digit_carry_flag <= pwdata[`ALUOP_FLAG_DC];
        negative_flag <= pwdata[`ALUOP_FLAG_N];
        overflow_flag <= pwdata[`ALUOP_FLAG_OV];
        zero_flag <= pwdata[`ALUOP_FLAG_Z];
      end
      if (do_alu) begin
        if (upd_c) carry_flag <= c_n; // [RULE1]
        if (upd_dc) digit_carry_flag <= dc_n;
        if (upd_ov) overflow_flag <= ov_n;
        if (upd_nz) begin
          negative_flag <= n_n;
          if (ins_op == `ALUOP_OP_ADD_WITH_CARRY) begin
            zero_flag <= zero_flag & z_n; // [RULE16]
          end else begin
            zero_flag <= z_n;
          end
        end
        result_q <= res[15:0];
      end
      file_wr_q <= do_alu & to_file;
      file_addr_q <= file_addr_field; // [RULE6]
      ea_valid_q <= exec & ~bad & mem_form;
      ea_q <= ea;
      // taken branch flushes the fetched successor
      branch_taken_q <= exec & ~bad & (ins_op == `ALUOP_OP_BRA) &
        cond_ok; // [RULE15]
      nop_cycle_q <= exec & ~bad & (ins_op == `ALUOP_OP_BRA) &
        cond_ok; // [RULE17]
      branch_offset_q <= simm_ext;
      illegal_q <= exec & bad;
      if (exec & (ins_op == `ALUOP_OP_BITSEL)) begin
        bit_value_q <= src_op[bit_index_field]; // [RULE5]
      end
      if (psel & ~penable) begin
        if (sel_st) begin
          prdata_q <= {27'h0, zero_flag, overflow_flag, negative_flag,
            digit_carry_flag, carry_flag};
        end else if (sel_ct) begin
          prdata_q <= {31'h0, ctrl_run_q};
        end else if (sel_rs) begin
          prdata_q <= {16'h0000, result_q};
        end else begin
          prdata_q <= 32'h0;
        end
      end else if (psel & penable & ~pready_q & sel_rf) begin
        prdata_q <= {16'h0000, rf_apb_rd};
      end
    end
  end

endmodule // aluop_core

// >>> hdl/aluop_defs.vh
// constants for the execute-stage datapath subset
// assumes inclusion by the datapath top, register file, checker and bench top
`ifndef ALUOP_DEFS_VH
`define ALUOP_DEFS_VH

// ==========================================================
// apb register map (byte addresses)
`define ALUOP_ADDR_STATUS 12'h000
`define ALUOP_ADDR_CTRL 12'h004
`define ALUOP_ADDR_RESULT 12'h008
`define ALUOP_ADDR_RF_BASE 12'h040
`define ALUOP_RF_SEL_MSB 11
`define ALUOP_RF_SEL_LSB 6
`define ALUOP_RF_SEL_VAL 6'h01
`define ALUOP_CTRL_RESET 1'h0

// ==========================================================
// status bit positions
`define ALUOP_FLAG_C 0
`define ALUOP_FLAG_DC 1
`define ALUOP_FLAG_N 2
`define ALUOP_FLAG_OV 3
`define ALUOP_FLAG_Z 4

// ==========================================================
// operations
`define ALUOP_OP_NOP 3'h0
`define ALUOP_OP_ADD 3'h1
`define ALUOP_OP_ADD_WITH_CARRY 3'h2
`define ALUOP_OP_ASR1 3'h3
`define ALUOP_OP_ASRN 3'h4
`define ALUOP_OP_BRA 3'h5
`define ALUOP_OP_BITSEL 3'h6

// ==========================================================
// operand sizes
`define ALUOP_SZ_WORD 2'h0
`define ALUOP_SZ_BYTE 2'h1
`define ALUOP_SZ_DWORD 2'h2

// ==========================================================
// source operand forms
`define ALUOP_SRC_REG 4'h0
`define ALUOP_SRC_IND 4'h1
`define ALUOP_SRC_POSTINC 4'h2
`define ALUOP_SRC_PREINC 4'h3
`define ALUOP_SRC_IDX 4'h4
`define ALUOP_SRC_IMM5 4'h5
`define ALUOP_SRC_IMM10 4'h6
`define ALUOP_SRC_SIMM10 4'h7
`define ALUOP_SRC_IMM8 4'h8
`define ALUOP_SRC_IMM16 4'h9
`define ALUOP_SRC_FILE 4'ha

// ==========================================================
// branch conditions
`define ALUOP_CC_C 2'h0
`define ALUOP_CC_GE 2'h1
`define ALUOP_CC_GEU 2'h2
`define ALUOP_CC_GT 2'h3

// ==========================================================
// literal limits and misc
`define ALUOP_IMM10_BYTE_MAX 10'h0ff
`define ALUOP_ACC_REG 4'h0
`define ALUOP_INC_BYTE 16'h0001
`define ALUOP_INC_WORD 16'h0002

`endif

// >>> hdl/aluop_regfile.v
// sixteen 16-bit working registers, flat view plus apb read port
// assumes single clock; port 0 beats port 1 on the same address
`timescale 1ns/1ps
`include "aluop_defs.vh"

module aluop_regfile (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // write ports
  input wire we0,
  input wire [3:0] wa0,
  input wire [15:0] wd0,
  input wire we1,
  input wire [3:0] wa1,
  input wire [15:0] wd1,
  // reads
  input wire [3:0] ra,
  output reg [15:0] rd_q,
  output wire [255:0] flat
);

  reg [15:0] mem [0:15];
  integer i;

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_flat
      assign flat[g*16 +: 16] = mem[g];
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 16; i = i + 1) begin
        mem[i] <= 16'h0000;
      end
      rd_q <= 16'h0000;
    end else begin
      rd_q <= mem[ra];
      if (we1) begin
        mem[wa1] <= wd1;
      end
      if (we0) begin
        mem[wa0] <= wd0;
      end
    end
  end

endmodule // aluop_regfile

// >>> tb/aluop_chk_sva.sv
// checker for the execute-stage datapath, sees the core ports only
// assumes one clock domain and a bind from the bench top file
`timescale 1ns/1ps
`include "aluop_defs.vh"

module aluop_chk (
  // clock and reset
  input logic pclk,
  input logic presetn,
  // apb
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic pready_q,
  input logic pslverr_q,
  // instruction
  input logic ins_valid,
  input logic [2:0] ins_op,
  input logic [1:0] ins_size,
  input logic [3:0] ins_src_mode,
  input logic [1:0] ins_cond,
  input logic [9:0] imm10_field,
  input logic [12:0] file_addr_field,
  input logic [22:0] prog_addr_literal,
  // results
  input logic carry_flag,
  input logic digit_carry_flag,
  input logic negative_flag,
  input logic overflow_flag,
  input logic zero_flag,
  input logic [15:0] result_q,
  input logic file_wr_q,
  input logic [12:0] file_addr_q,
  input logic branch_taken_q,
  input logic nop_cycle_q,
  input logic illegal_q
);
  // ==========================================================
  // helper: shadow of the run bit, set by completed ctrl writes
  logic run_q;
  logic tk;
  logic [4:0] st;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) run_q <= 1'b0;
    else if (psel && penable && pready_q && pwrite &&
             paddr == `ALUOP_ADDR_CTRL) run_q <= pwdata[0];
  end
  assign tk = ins_valid && run_q && !nop_cycle_q;
  assign st = {zero_flag, overflow_flag, negative_flag,
               digit_carry_flag, carry_flag};

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // properties
  sequence apb_setup; psel && !penable; endsequence
  sequence apb_access; psel && penable; endsequence

  apb_wait_a: assert property (apb_setup ##1 apb_access |=> pready_q)
    else $error("pready late");
  apb_pulse_a: assert property (pready_q |=> !pready_q)
    else $error("pready held");
  add_nz_a: assert property (tk && ins_op == `ALUOP_OP_ADD &&
    ins_size == `ALUOP_SZ_WORD |=> zero_flag == (result_q == 16'h0)
    && negative_flag == result_q[15]) else $error("add flags");
  add_with_carry_zero_a: assert property (tk && ins_op == `ALUOP_OP_ADD_WITH_CARRY &&
    !zero_flag |=> !zero_flag) else $error("zero set by add_with_carry");
  asr_one_a: assert property (tk && ins_op == `ALUOP_OP_ASR1 &&
    ins_size == `ALUOP_SZ_WORD |=> !overflow_flag &&
    negative_flag == result_q[15]) else $error("asr one flags");
  asr_n_a: assert property (tk && ins_op == `ALUOP_OP_ASRN |=>
    $stable({carry_flag, digit_carry_flag, overflow_flag}))
    else $error("asr count touched c dc ov");
  bra_carry_a: assert property (tk && ins_op == `ALUOP_OP_BRA &&
    ins_cond == `ALUOP_CC_C && !prog_addr_literal[0] |=>
    branch_taken_q == $past(carry_flag)) else $error("branch on c");
  bra_flags_a: assert property (branch_taken_q |->
    $stable(st) && nop_cycle_q) else $error("taken branch flags");
  flush_once_a: assert property (nop_cycle_q |=>
    !nop_cycle_q && !branch_taken_q) else $error("flush slot ran");
  imm_byte_a: assert property (tk && ins_op == `ALUOP_OP_ADD &&
    ins_size == `ALUOP_SZ_BYTE && ins_src_mode == `ALUOP_SRC_IMM10 &&
    imm10_field > `ALUOP_IMM10_BYTE_MAX |=> illegal_q)
    else $error("byte literal not refused");
  file_addr_a: assert property (file_wr_q |->
    file_addr_q == $past(file_addr_field)) else $error("file addr");
endmodule // aluop_chk

// >>> tb/tb_top.sv
// self-checking bench for the execute-stage datapath core
// assumes the core hands over as noted: apb one wait state
`timescale 1ns/1ps
`include "aluop_defs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t got %h exp %h", $time, g, e); end end

module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic ins_valid = 0, ins_to_acc = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [2:0] ins_op = 0;
  logic [1:0] ins_size = 0, ins_cond = 0;
  logic [3:0] ins_src_mode = 0, base_reg_field = 0, bit_index_field = 0;
  logic [3:0] source_reg_field = 0, dest_reg_field = 0;
  logic [4:0] imm5_field = 0;
  logic [9:0] imm10_field = 0, simm10_field = 0;
  logic [7:0] imm8_field = 0;
  logic [15:0] imm16_field = 0, mem_operand = 0;
  logic [12:0] file_addr_field = 0;
  logic [22:0] prog_addr_literal = 0;
  wire [31:0] prdata_q;
  wire [15:0] result_q, ea_q, branch_offset_q;
  wire [12:0] file_addr_q;
  wire pready_q, pslverr_q, carry_flag, digit_carry_flag, negative_flag;
  wire overflow_flag, zero_flag, file_wr_q, ea_valid_q, branch_taken_q;
  wire nop_cycle_q, bit_value_q, illegal_q;
  wire [4:0] st = {zero_flag, overflow_flag, negative_flag,
                   digit_carry_flag, carry_flag};
  int fails = 0, n_checks = 0;

  always #20 pclk = ~pclk;
  aluop_core uut (.*);

  // ==========================================================
  // bus and instruction drivers
  function automatic logic [11:0] ra(input int n);
    return `ALUOP_ADDR_RF_BASE + 12'(4 * n);
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready_q !== 1'b1) @(posedge pclk);
    rd = prdata_q; er = pslverr_q; psel <= 0; penable <= 0;
  endtask
  task ex(input logic [2:0] o, input logic [1:0] z,
          input logic [3:0] m, b, s, d);
    @(posedge pclk);
    ins_valid <= 1; ins_op <= o; ins_size <= z; ins_src_mode <= m;
    base_reg_field <= b; source_reg_field <= s; dest_reg_field <= d;
    @(posedge pclk);
    ins_valid <= 0;
    #1;
  endtask

  // ==========================================================
  // scenarios
  task t_load;
    apb(0, `ALUOP_ADDR_STATUS, 0); `CHK(rd, 32'h0)
    apb(1, ra(1), 32'h7fff); apb(1, ra(2), 32'h1);
    apb(1, ra(3), 32'h8000); apb(1, ra(15), 32'ha5a5);
    apb(0, ra(15), 0); `CHK(rd, 32'ha5a5)
    apb(0, ra(16), 0); `CHK(er, 1'b1)
    apb(1, `ALUOP_ADDR_CTRL, 32'h1);
  endtask
  task t_arith;
    ex(`ALUOP_OP_ADD, `ALUOP_SZ_WORD, `ALUOP_SRC_REG, 1, 2, 4);
    `CHK(result_q, 16'h8000) `CHK(st, 5'h0e)
    ex(`ALUOP_OP_ADD_WITH_CARRY, `ALUOP_SZ_WORD, `ALUOP_SRC_REG, 3, 3, 6);
    `CHK(result_q, 16'h0) `CHK(st, 5'h09)
    @(posedge pclk) imm5_field <= 5'h1f;
    ex(`ALUOP_OP_ASRN, `ALUOP_SZ_WORD, `ALUOP_SRC_IMM5, 3, 3, 7);
    `CHK(result_q, 16'hffff) `CHK(st, 5'h0d)
  endtask
  task t_branch;
    @(posedge pclk);
    ins_valid <= 1; ins_op <= `ALUOP_OP_BRA; simm10_field <= 10'h3f0;
    @(posedge pclk);
    ins_op <= `ALUOP_OP_ADD; ins_src_mode <= `ALUOP_SRC_REG;
    base_reg_field <= 1; source_reg_field <= 2; dest_reg_field <= 8;
    #1 `CHK({branch_taken_q, nop_cycle_q}, 2'b11)
    `CHK(branch_offset_q, 16'hfff0)
    @(posedge pclk) ins_valid <= 0;
    #1 `CHK(result_q, 16'hffff)
    `CHK(st, 5'h0d)
    apb(0, ra(8), 0); `CHK(rd, 32'h0)
    ex(`ALUOP_OP_ASR1, `ALUOP_SZ_WORD, `ALUOP_SRC_REG, 3, 3, 5);
    `CHK(result_q, 16'hc000) `CHK(st, 5'h04)
    @(posedge pclk) prog_addr_literal <= 23'h1;
    ex(`ALUOP_OP_BRA, `ALUOP_SZ_WORD, `ALUOP_SRC_REG, 0, 0, 0);
    `CHK({branch_taken_q, nop_cycle_q}, 2'b00)
    `CHK(illegal_q, 1'b1)
  endtask
  task t_operands;
    @(posedge pclk) imm10_field <= 10'h100;
    ex(`ALUOP_OP_ADD, `ALUOP_SZ_BYTE, `ALUOP_SRC_IMM10, 10, 10, 10);
    `CHK(illegal_q, 1'b1)
    @(posedge pclk) imm10_field <= 10'h3ff;
    ex(`ALUOP_OP_ADD, `ALUOP_SZ_WORD, `ALUOP_SRC_IMM10, 9, 9, 9);
    `CHK({illegal_q, result_q}, 17'h003ff)
    @(posedge pclk);
    mem_operand <= 16'h5; file_addr_field <= 13'h1fff; ins_to_acc <= 1;
    ex(`ALUOP_OP_ADD, `ALUOP_SZ_WORD, `ALUOP_SRC_FILE, 0, 0, 0);
    apb(0, ra(0), 0); `CHK(rd, 32'h5)
    @(posedge pclk) ins_to_acc <= 0;
    ex(`ALUOP_OP_ADD, `ALUOP_SZ_WORD, `ALUOP_SRC_FILE, 0, 0, 0);
    `CHK({file_wr_q, file_addr_q, result_q}, 30'h3fff000a)
    ex(`ALUOP_OP_ADD, `ALUOP_SZ_WORD, `ALUOP_SRC_IDX, 1, 2, 11);
    `CHK({ea_valid_q, ea_q}, 17'h18000)
  endtask
  task t_sizes;
    ex(`ALUOP_OP_ADD, `ALUOP_SZ_DWORD, `ALUOP_SRC_REG, 1, 2, 13);
    `CHK(result_q, 16'h8000) `CHK(st, 5'h04)
    apb(0, ra(14), 0); `CHK(rd, 32'h8001)
    ex(`ALUOP_OP_ADD, `ALUOP_SZ_BYTE, `ALUOP_SRC_REG, 1, 2, 1);
    `CHK(st, 5'h13)
    apb(0, ra(1), 0); `CHK(rd, 32'h7f00)
    ex(`ALUOP_OP_ADD, `ALUOP_SZ_WORD, `ALUOP_SRC_IMM5, 3, 0, 15);
    `CHK(result_q, 16'h801f)
    @(posedge pclk) imm8_field <= 8'hff;
    ex(`ALUOP_OP_ADD, `ALUOP_SZ_WORD, `ALUOP_SRC_IMM8, 2, 0, 15);
    `CHK(result_q, 16'h0100)
    @(posedge pclk) bit_index_field <= 4'hf;
    ex(`ALUOP_OP_BITSEL, `ALUOP_SZ_WORD, `ALUOP_SRC_REG, 0, 3, 0);
    `CHK(bit_value_q, 1'b1)
    @(posedge pclk) bit_index_field <= 4'he;
    ex(`ALUOP_OP_BITSEL, `ALUOP_SZ_WORD, `ALUOP_SRC_REG, 0, 3, 0);
    `CHK(bit_value_q, 1'b0)
    ex(`ALUOP_OP_ADD, `ALUOP_SZ_WORD, `ALUOP_SRC_POSTINC, 2, 4, 12);
    `CHK({ea_valid_q, ea_q}, 17'h18000)
    apb(0, ra(4), 0); `CHK(rd, 32'h8002)
    apb(0, `ALUOP_ADDR_RESULT, 0); `CHK(rd, 32'h6)
    @(posedge pclk);
    ins_cond <= `ALUOP_CC_GT; prog_addr_literal <= 23'h0;
    ex(`ALUOP_OP_BRA, `ALUOP_SZ_WORD, `ALUOP_SRC_REG, 0, 0, 0);
    `CHK({branch_taken_q, nop_cycle_q}, 2'b11)
    apb(1, `ALUOP_ADDR_STATUS, 32'h1f);
    apb(0, `ALUOP_ADDR_STATUS, 0); `CHK(rd, 32'h1f)
    ex(`ALUOP_OP_BRA, `ALUOP_SZ_WORD, `ALUOP_SRC_REG, 0, 0, 0);
    `CHK({branch_taken_q, nop_cycle_q}, 2'b00)
    apb(1, ra(5), 32'h1234);
    apb(0, ra(5), 0); `CHK(rd, 32'hc000)
  endtask

  // ==========================================================
  // run control
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    t_load;
    t_arith;
    t_branch;
    t_operands;
    t_sizes;
    close_out;
  end
  // far beyond the hundred and fifty or so cycles the scenarios need
  initial begin
    #200000;
    fails++;
    close_out;
  end
endmodule // tb_top

bind aluop_core aluop_chk u_chk (.*);
